// ### rtl/rabs_cfg.svh
// Purpose: constants of the read-after-write block sequencer
// Assumes: pclk at 200 MHz, APB byte addresses
// Notes:   times kept in their own unit, cycle counts derived from them
`ifndef RABS_CFG_SVH
`define RABS_CFG_SVH

// register byte offsets
`define RABS_ADDR_CTRL     12'h000
`define RABS_ADDR_PERIOD   12'h004
`define RABS_ADDR_STATUS   12'h008

// control field positions
`define RABS_CTRL_ERR_STOP 0
`define RABS_CTRL_CYCLE    1
`define RABS_CTRL_ODD      2
`define RABS_CTRL_RESET    32'h0000_0002

// status field positions
`define RABS_ST_START      0
`define RABS_ST_DRIVE      1
`define RABS_ST_ERRSTOP    2
`define RABS_ST_VERT       3
`define RABS_ST_DISPLAY    4
`define RABS_ST_LONG       5
`define RABS_ST_PHASE      16

// nominal read clock period in pclk cycles (160 ns)
`define RABS_PERIOD_RESET  16'h0020

// timing
`define RABS_CLK_NS        5
`define RABS_CLK_PER_MS    200000
`define RABS_RDPULSE_NS    2000
`define RABS_END_BLOCK_NS  2000
`define RABS_DISPLAY_MS    250
`define RABS_CHECK_PERIODS 10
`define RABS_RDPULSE_CYC   (`RABS_RDPULSE_NS / `RABS_CLK_NS)
`define RABS_END_BLOCK_CYC (`RABS_END_BLOCK_NS / `RABS_CLK_NS)
`define RABS_DISPLAY_CYC   (`RABS_DISPLAY_MS * `RABS_CLK_PER_MS)

`endif

// ### rtl/rabs_pkg.sv
// Purpose: types of the read-after-write block sequencer
// Assumes: nine-track characters
// Notes:   constants live in rabs_cfg.svh
package rabs_pkg;

  // one character as read from tape
  typedef struct packed {
    logic       parity;
    logic [7:0] data;
  } rabs_char_t;

  // block sequence phases
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_RUN   = 2'b01,
    PH_CHECK = 2'b10,
    PH_DISP  = 2'b11
  } rabs_phase_t;

endpackage

// ### rtl/rabs_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to pclk
// Notes:   only the second stage may be read
`timescale 1ns/1ps
`default_nettype none
module rabs_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### rtl/rabs_timer.sv
// Purpose: retriggerable down-counter standing in for a one-shot
// Assumes: value of zero is treated as one cycle
// Notes:   busy lasts exactly value cycles after the load edge
`timescale 1ns/1ps
`default_nettype none
module rabs_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic [31:0] value,
  output logic             busy,
  output logic             done
);
  logic [31:0] cnt_r;

  // reload on every trigger, so a fresh trigger extends the interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 32'h0000_0000;
    end else if (load) begin
      cnt_r <= (value == 32'h0000_0000) ? 32'h0000_0001 : value;
    end else if (cnt_r != 32'h0000_0000) begin
      cnt_r <= cnt_r - 32'h0000_0001;
    end
  end

  assign busy = (cnt_r != 32'h0000_0000);
  assign done = (cnt_r == 32'h0000_0001) && !load;
endmodule
`default_nettype wire

// ### rtl/rabs_seq.sv
// Purpose: read-after-write block sequencer with APB control
// Assumes: read clock and tracks arrive from the tape unit unsynchronised
// Notes:   all one-shots replaced by counters on pclk
// Notes on behaviour
// RL1: block starts from auto start after evaluation, or operator error-stop toggle.
// RL2: error latch under error-stop blocks the auto start pulse.
// RL3: switching error-stop to normal makes a start trigger bypassing the inhibit.
// RL4: normal never halts on errors; error-stop continues while no error seen.
// RL5: start pulse clears vertical latch and longitudinal detectors.
// RL6: start sets start latch, which sets drive latch; forward-only asserts forward command.
// RL7: tape unit moves forward only in its read-block setting.
// RL8: each read clock gives an internal pulse two microseconds long.
// RL9: first read clock clears start latch and starts end-of-data timer.
// RL10: end-of-data timer retriggers; fires 2-1/2 periods after last clock.
// RL11: vertical mismatch at a clock drives vertical error, sets lamp latch.
// RL12: wait ten periods after end of data before end-of-block.
// RL13: vertical errors suppressed during the ten-period check interval.
// RL14: two-microsecond end-of-block pulse clears drive latch, starts display.
// RL15: tape unit halts when forward command drops.
// RL16: display lasts 250 ms, lights per-track lamps, signals to board.
// RL17: write permit held low for the whole display period.
// RL18: any track error in display drives longitudinal error low.
// RL19: combiner ORs errors; under error-stop it sets the error latch.
// RL20: display end restarts the next block unless error-stopped.
// RL21: end-of-data span and check delay share one period setting.
// RL22: nine detectors cleared at start, toggled per one bit, odd flags.
// RL23: odd/even selection; mismatch of nine-bit ones count flags error.
// RL24: intervals counted on pclk in units of the period setting.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rabs_cfg.svh"
module rabs_seq #(
  parameter logic [31:0] DISPLAY_CYC = `RABS_DISPLAY_CYC
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 read_clk,
  input  wire rabs_pkg::rabs_char_t read_char,
  output logic                      forward_command_n,
  output logic                      vert_error_n,
  output logic                      long_error_n,
  output logic                      display_period,
  output logic                      write_permit,
  output logic                      lateral_parity_lamp,
  output logic      [8:0]           long_lamps
);
  import rabs_pkg::*;

  logic [31:0] ctrl_r;
  logic [15:0] period_r;
  logic        error_stop_select;
  logic        cycle_select;
  logic        odd_select;
  rabs_char_t  char_s;
  logic        rclk_s;
  logic        rclk_q_r;
  logic        rclk_rise;
  rabs_phase_t phase_r;
  logic        start_latch_r;
  logic        drive_latch_r;
  logic        err_latch_r;
  logic        vert_latch_r;
  logic        vert_hit_r;
  logic        err_stop_q_r;
  logic        manual_trig;
  logic        auto_start;
  logic        start_trig;
  logic [8:0]  long_det_r;
  logic        long_any;
  logic        err_any;
  logic        rd_busy;
  logic        end_data_done;
  logic        chk_done;
  logic        end_block_busy;
  logic        disp_busy;
  logic        disp_done;
  logic [31:0] end_data_len;
  logic [31:0] chk_len;
  logic        wr_en;
  logic        rd_setup;
  logic        addr_ok;
  logic [31:0] status;

  assign error_stop_select = ctrl_r[`RABS_CTRL_ERR_STOP];
  assign cycle_select      = ctrl_r[`RABS_CTRL_CYCLE];
  assign odd_select        = ctrl_r[`RABS_CTRL_ODD];

  // apb slave: zero wait states, read data captured in the setup cycle
  assign addr_ok  = (paddr == `RABS_ADDR_CTRL) || (paddr == `RABS_ADDR_PERIOD)
                 || (paddr == `RABS_ADDR_STATUS);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addr_ok;
  assign wr_en    = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= `RABS_CTRL_RESET;
      period_r <= `RABS_PERIOD_RESET;
    end else if (wr_en && paddr == `RABS_ADDR_CTRL) begin
      ctrl_r   <= pwdata & 32'h0000_0007;
    end else if (wr_en && paddr == `RABS_ADDR_PERIOD) begin
      period_r <= pwdata[15:0];
    end
  end

  assign status = {14'h0000, phase_r, 2'h0, long_det_r, display_period,
                   vert_latch_r, err_latch_r, drive_latch_r, start_latch_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        `RABS_ADDR_CTRL:   prdata <= ctrl_r;
        `RABS_ADDR_PERIOD: prdata <= {16'h0000, period_r};
        `RABS_ADDR_STATUS: prdata <= status;
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

  // pin inputs pass two flops; the edge detector looks only at stage two
  rabs_sync #(.W(10)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({read_clk, read_char}),
    .q       ({rclk_s, char_s})
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rclk_q_r <= 1'b0;
    end else begin
      rclk_q_r <= rclk_s;
    end
  end
  assign rclk_rise = rclk_s && !rclk_q_r;

  // both windows from one period figure, so they cannot drift apart
  assign end_data_len = (32'(period_r) * 32'h0000_0005) >> 1; // see RL21 see RL24
  assign chk_len      = 32'(period_r) * `RABS_CHECK_PERIODS;  // see RL21 see RL24

  // internal read clock pulse, re-armed by each incoming clock
  rabs_timer u_rdpulse (                               // see RL8
    .pclk    (pclk),
    .presetn (presetn),
    .load    (rclk_rise),
    .value   (32'(`RABS_RDPULSE_CYC)),
    .busy    (rd_busy),
    .done    ()
  );

  // end-of-data detect, retriggered by every clock while running
  rabs_timer u_end_data (                              // see RL9 see RL10
    .pclk    (pclk),
    .presetn (presetn),
    .load    (rclk_rise && phase_r == PH_RUN),
    .value   (end_data_len),
    .busy    (),
    .done    (end_data_done)
  );

  // check-character interval after end of data
  rabs_timer u_chk (                                   // see RL12
    .pclk    (pclk),
    .presetn (presetn),
    .load    (end_data_done && phase_r == PH_RUN),
    .value   (chk_len),
    .busy    (),
    .done    (chk_done)
  );

  // end-of-block pulse and display period start together
  rabs_timer u_end_block (                             // see RL14
    .pclk    (pclk),
    .presetn (presetn),
    .load    (chk_done && phase_r == PH_CHECK),
    .value   (32'(`RABS_END_BLOCK_CYC)),
    .busy    (end_block_busy),
    .done    ()
  );

  rabs_timer u_disp (                                  // see RL16
    .pclk    (pclk),
    .presetn (presetn),
    .load    (chk_done && phase_r == PH_CHECK),
    .value   (DISPLAY_CYC),
    .busy    (disp_busy),
    .done    (disp_done)
  );

  // start triggers: the manual one ignores the error inhibit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_stop_q_r <= 1'b0;
    end else begin
      err_stop_q_r <= error_stop_select;
    end
  end
  assign manual_trig = err_stop_q_r && !error_stop_select;              // see RL3
  assign auto_start  = disp_done && phase_r == PH_DISP && !err_latch_r; // see RL2 see RL20
  assign start_trig  = auto_start || manual_trig;                       // see RL1

  // phase sequencing; late clocks in display are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= PH_IDLE;
    end else begin
      unique case (phase_r)
        PH_IDLE:  if (start_trig) phase_r <= PH_RUN;
        PH_RUN:   if (end_data_done) phase_r <= PH_CHECK;
        PH_CHECK: if (chk_done) phase_r <= PH_DISP;
        PH_DISP:  if (disp_done) phase_r <= auto_start ? PH_RUN : PH_IDLE;
      endcase
    end
  end

  // start latch: set by a trigger, cleared by the first read clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_latch_r <= 1'b0;
    end else if (start_trig) begin
      start_latch_r <= 1'b1;                                  // see RL6
    end else if (rclk_rise) begin
      start_latch_r <= 1'b0;                                  // see RL9
    end
  end

  // drive latch: held from start until end-of-block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_latch_r <= 1'b0;
    end else if (start_latch_r) begin
      drive_latch_r <= 1'b1;                                  // see RL6
    end else if (chk_done && phase_r == PH_CHECK) begin
      drive_latch_r <= 1'b0;                                  // see RL14
    end
  end

  // reverse cycling is not built; only forward-only drives the tape
  assign forward_command_n = !(drive_latch_r && cycle_select); // see RL6 see RL15

  // vertical check only in data time, never over the check characters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vert_hit_r <= 1'b0;
    end else if (rclk_rise) begin
      vert_hit_r <= (phase_r == PH_RUN) && ((^char_s) != odd_select); // see RL23 see RL13
    end
  end
  assign vert_error_n = !(vert_hit_r && rd_busy && phase_r == PH_RUN); // see RL11 see RL13

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vert_latch_r <= 1'b0;
    end else if (!vert_error_n) begin
      vert_latch_r <= 1'b1;                                   // see RL11
    end else if (start_trig) begin
      vert_latch_r <= 1'b0;                                   // see RL5
    end
  end
  assign lateral_parity_lamp = vert_latch_r;

  // one toggle detector per track; check characters are included
  for (genvar t = 0; t < 9; t++) begin : g_long
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        long_det_r[t] <= 1'b0;
      end else if (start_trig) begin
        long_det_r[t] <= 1'b0;                                // see RL5 see RL22
      end else if (rclk_rise && (phase_r == PH_RUN || phase_r == PH_CHECK)
                   && char_s[t]) begin
        long_det_r[t] <= !long_det_r[t];                      // see RL22
      end
    end
  end

  assign display_period = disp_busy;                          // see RL16
  assign write_permit   = !disp_busy;                         // see RL17
  assign long_lamps     = disp_busy ? long_det_r : 9'h000;    // see RL16
  assign long_any       = disp_busy && (|long_det_r);
  assign long_error_n   = !long_any;                          // see RL18
  assign err_any        = vert_latch_r || long_any;           // see RL19

  // error-stop latch; going to normal releases it at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_latch_r <= 1'b0;
    end else if (!error_stop_select) begin
      err_latch_r <= 1'b0;                                    // see RL4
    end else if (err_any) begin
      err_latch_r <= 1'b1;                                    // see RL19 see RL2
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [31:0] chk_run_h;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_run_h <= 32'h0000_0000;
    end else begin
      chk_run_h <= (phase_r == PH_CHECK) ? chk_run_h + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  chk_start_drive:  assert property (start_latch_r |=> drive_latch_r)          // see RL6
    else $error("drive latch not set after start latch");
  chk_manual_start: assert property ($fell(error_stop_select) |=> start_latch_r) // see RL3
    else $error("manual toggle did not set start latch");
  chk_auto_block:   assert property (disp_done && phase_r == PH_DISP && err_latch_r // see RL2
                                     && !manual_trig |=> !start_latch_r)
    else $error("auto start passed under error stop");
  chk_first_clock:  assert property (rclk_rise && start_latch_r && !start_trig // see RL9
                                     |=> !start_latch_r)
    else $error("first read clock left start latch set");
  chk_rd_pulse:     assert property (rclk_rise |=> rd_busy [*8])            // see RL8
    else $error("read pulse shorter than expected");
  chk_check_len:    assert property (phase_r == PH_CHECK && chk_done // see RL12
                                     |-> chk_run_h == chk_len - 32'h0000_0001)
    else $error("check interval length wrong");
  chk_vert_quiet:   assert property (phase_r != PH_RUN && !vert_latch_r |=> !vert_latch_r) // see RL13
    else $error("vertical lamp lit outside data time");
  chk_block_end:    assert property (phase_r == PH_CHECK && chk_done // see RL14
                                     |=> !drive_latch_r && end_block_busy && disp_busy)
    else $error("end of block did not stop drive");
  chk_write_block:  assert property (phase_r == PH_DISP |-> !write_permit && display_period) // see RL17
    else $error("write permitted in display");
  chk_long_error:   assert property (disp_busy && long_det_r != 9'h000 |-> !long_error_n) // see RL18
    else $error("longitudinal error not reported");
  chk_err_set:      assert property (error_stop_select && $past(error_stop_select) // see RL19
                                     && err_any |=> err_latch_r)
    else $error("error stop latch not set");
  chk_resume:       assert property (phase_r == PH_DISP && disp_done && !err_latch_r // see RL20
                                     |=> start_latch_r && phase_r == PH_RUN)
    else $error("no restart after display");

  cov_block_done:  cover property (phase_r == PH_CHECK ##1 phase_r == PH_DISP);
  cov_error_stop:  cover property (disp_done && err_latch_r);
  cov_manual:      cover property ($fell(error_stop_select));
  cov_vert_error:  cover property (!vert_error_n);
endmodule
`default_nettype wire

// ### bench/rabs_tape_model.sv
// Purpose: behavioural tape unit that feeds read clock and characters
// Assumes: read clock period of 160 ns, forward command active low
// Notes:   check characters follow the data after four-period gaps
`timescale 1ns/1ps
`default_nettype none
module rabs_tape_model #(
  parameter int NCHR = 12
) (
  input  wire logic            pclk,
  input  wire logic            forward_command_n,
  input  wire logic            read_block,
  input  wire logic            odd_sel,
  input  wire logic [7:0]      bad_vert,
  input  wire logic            bad_long,
  output logic                 read_clk,
  output rabs_pkg::rabs_char_t read_char
);
  import rabs_pkg::*;
  logic [8:0] lrc;
  logic [8:0] ch;
  // one block per forward command; the clock stands still between blocks
  initial begin
    read_clk  = 1'b0;
    read_char = '0;
    forever begin
      @(posedge pclk iff (!forward_command_n && read_block));
      #1; // step off the sampling edge so the pins never race the clock
      lrc = 9'h000;
      for (int i = 0; i < NCHR + 2; i++) begin
        if (i >= NCHR) #480; // four-period gap before each check character
        ch[7:0] = 8'(i * 8'h25 + 8'h13);
        ch[8]   = (^ch[7:0]) ^ odd_sel ^ (bad_vert == 8'(i + 1));
        if (i == NCHR) ch = 9'h0F0; // cyclic check char, vertical parity not kept
        if (i == NCHR + 1) ch = lrc ^ {8'h00, bad_long}; // longitudinal check char
        lrc = lrc ^ ch;
        read_char = ch;
        #40 read_clk = 1'b1;
        #80 read_clk = 1'b0;
        read_char = ~ch; // hold time over: lines must not keep the last value
        #40;
      end
      // tape stops only once the command is withdrawn
      wait (forward_command_n === 1'b1);
    end
  end
endmodule
`default_nettype wire

// ### bench/tb_read_after_write_block_sequencer.sv
// Purpose: self-checking bench for the read-after-write block sequencer
// Assumes: read clock of 160 ns, display shortened to 2000 cycles
// Notes:   setup changes are made between blocks, except t_stop selecting error stop while a block runs
`timescale 1ns/1ps
`default_nettype none
`include "rabs_cfg.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fail_count++; \
  $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module tb_read_after_write_block_sequencer;
  import rabs_pkg::*;
  localparam logic [31:0] DISP_CYC = 32'h0000_07D0;
  logic       pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic       read_clk, forward_command_n, vert_error_n, long_error_n;
  logic       display_period, write_permit, lateral_parity_lamp;
  logic [8:0] long_lamps;
  rabs_char_t read_char;
  logic       read_block, odd_sel, bad_long, saw_vert;
  logic [7:0] bad_vert;
  int         fail_count, cmp_count;
  realtime    last_clk, prev_clk;

  rabs_seq #(.DISPLAY_CYC(DISP_CYC)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .read_clk(read_clk), .read_char(read_char),
    .forward_command_n(forward_command_n), .vert_error_n(vert_error_n),
    .long_error_n(long_error_n), .display_period(display_period),
    .write_permit(write_permit), .lateral_parity_lamp(lateral_parity_lamp),
    .long_lamps(long_lamps));
  rabs_tape_model tape (.pclk(pclk), .forward_command_n(forward_command_n),
    .read_block(read_block), .odd_sel(odd_sel), .bad_vert(bad_vert), .bad_long(bad_long),
    .read_clk(read_clk), .read_char(read_char));

  always #2.5 pclk = ~pclk;
  // last data clock: check characters come after a long gap and are skipped;
  // also any vertical error since the flag was cleared
  always @(posedge read_clk) begin
    if ($realtime - prev_clk < 300.0) last_clk = $realtime;
    prev_clk = $realtime;
  end
  always @(posedge pclk) if (vert_error_n === 1'b0) saw_vert <= 1'b1;

  task automatic report_and_stop;
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK("apb ready", 1'b1, pready)
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] m,
                        input logic [31:0] ex, input logic ex_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    `CHK(nm, ex, r & m)
    `CHK(nm, ex_err, e)
  endtask

  // bounded wait on forward command (which=0) or display period (which=1)
  task automatic wait_for(input logic which, input logic v, input int lim, output int n);
    n = 0;
    while ((which ? display_period : forward_command_n) !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    // long waits must never run out; short ones are judged by the caller
    if (lim > 400) `CHK("wait in time", 1'b1, n < lim)
  endtask

  task automatic t_reset;
    `CHK("forward idle", 1'b1, forward_command_n)
    `CHK("permit idle", 1'b1, write_permit)
    rd_chk("ctrl reset", `RABS_ADDR_CTRL, 32'hFFFF_FFFF, `RABS_CTRL_RESET, 1'b0);
    rd_chk("period reset", `RABS_ADDR_PERIOD, 32'hFFFF_FFFF, 32'h0000_0020, 1'b0);
    rd_chk("status reset", `RABS_ADDR_STATUS, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
    rd_chk("unmapped", 12'h00C, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
  endtask

  // manual start, clean block, timing of end of block, auto restart
  task automatic t_clean;
    int      n;
    realtime dt;
    saw_vert <= 1'b0;
    wr(`RABS_ADDR_CTRL, 32'h0000_0003);
    wr(`RABS_ADDR_CTRL, 32'h0000_0002);
    wait_for(1'b0, 1'b0, 4, n);
    `CHK("manual start", 1'b1, n < 4)
    wait_for(1'b1, 1'b1, 4000, n);
    dt = $realtime - last_clk;
    `CHK("end of block delay", 1'b1, dt >= 2015.0 && dt <= 2060.0)
    `CHK("forward halted", 1'b1, forward_command_n)
    `CHK("write blocked", 1'b0, write_permit)
    `CHK("no long lamps", 9'h000, long_lamps)
    `CHK("no vert error", 1'b0, saw_vert)
    `CHK("long error idle", 1'b1, long_error_n)
    wait_for(1'b1, 1'b0, 4000, n);
    `CHK("display length", DISP_CYC, 32'(n))
    wait_for(1'b0, 1'b0, 4, n);
    `CHK("auto restart", 1'b1, n < 4)
  endtask

  // odd parity with one bad character under normal selection
  task automatic t_vert;
    int n;
    wait_for(1'b1, 1'b1, 4000, n);
    odd_sel  <= 1'b1;
    bad_vert <= 8'h03;
    wr(`RABS_ADDR_CTRL, 32'h0000_0006);
    wait_for(1'b1, 1'b0, 4000, n);
    saw_vert <= 1'b0;
    wait_for(1'b1, 1'b1, 4000, n);
    `CHK("vert error seen", 1'b1, saw_vert)
    `CHK("lateral lamp", 1'b1, lateral_parity_lamp)
    `CHK("long lamps clean", 9'h000, long_lamps)
  endtask

  // track error under error stop, hold, then manual restart
  task automatic t_stop;
    int n;
    bad_vert <= 8'h00;
    bad_long <= 1'b1;
    wait_for(1'b1, 1'b0, 4000, n);
    wait_for(1'b0, 1'b0, 4, n);
    `CHK("restart after error", 1'b1, n < 4)
    `CHK("lamp cleared", 1'b0, lateral_parity_lamp)
    saw_vert <= 1'b0;
    wr(`RABS_ADDR_CTRL, 32'h0000_0007);
    wait_for(1'b1, 1'b1, 4000, n);
    `CHK("track lamp", 9'h001, long_lamps)
    `CHK("long error out", 1'b0, long_error_n)
    `CHK("check chars quiet", 1'b0, saw_vert)
    rd_chk("stop latched", `RABS_ADDR_STATUS, 32'h0000_0004, 32'h0000_0004, 1'b0);
    wait_for(1'b1, 1'b0, 4000, n);
    wait_for(1'b0, 1'b0, 400, n);
    `CHK("held by error stop", 1'b1, n >= 400)
    bad_long <= 1'b0;
    wr(`RABS_ADDR_CTRL, 32'h0000_0006);
    wait_for(1'b0, 1'b0, 4, n);
    `CHK("manual restart", 1'b1, n < 4)
    rd_chk("cleared", `RABS_ADDR_STATUS, 32'h0000_3FE4, 32'h0000_0000, 1'b0);
    wait_for(1'b1, 1'b1, 4000, n);
    `CHK("clean after clear", 9'h000, long_lamps)
  endtask

  // main sequence
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; read_block = 1'b1; odd_sel = 1'b0;
    bad_long = 1'b0; bad_vert = 8'h00; saw_vert = 1'b0; fail_count = 0; cmp_count = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_clean;
    t_vert;
    t_stop;
    report_and_stop;
  end

  // watchdog: the full run needs about 12000 cycles
  initial begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire
